// ---- hdl/packed_simd_alu.sv ----
// Behaviour
// - Halving halfword subtract: 17-bit difference, shift.
// - Halving byte subtract: four differences, halved.
// - Packed operations leave all flags unchanged.
// - Halfword subtract: two lanes, first minus second.
// - Byte subtract: four lanes, first minus second.
// - Add-sub exchange: sum top, difference bottom.
// - Sub-add exchange: difference top, sum bottom.
// - Bit test ANDs, sets flags, writes nothing.
// - Equivalence test XORs, sets flags, writes nothing.
// - Tests: N,Z from value; C shift; V kept.
// - Equivalence test: N is XOR of signs.
// - Unsigned halfword add, no carry between lanes.
// - Unsigned byte add, no carry between lanes.
// - Result and flag effects happen only when condition passes.
`timescale 1ns/10ps
module packed_simd_alu (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             result_we,
    output logic      [3:0]  result_dest,
    output logic      [31:0] result_data,
    output logic      [3:0]  flags_out
);
    typedef struct packed {
        logic [31:0] first;
        logic [31:0] second;
        logic [31:0] ctrl;
        logic [31:0] result;
        logic [3:0]  flags;
        logic [3:0]  dest;
        logic        pend;
        logic        ran;
        logic        wrote;
        logic        flagged;
        logic        bad;
        logic        result_we;
        logic [31:0] rdata;
        logic        slverr;
    } state_t;

    localparam state_t STATE_RESET = '{
        first:     simd_alu_pkg::WORD_RESET,
        second:    simd_alu_pkg::WORD_RESET,
        ctrl:      simd_alu_pkg::WORD_RESET,
        result:    simd_alu_pkg::WORD_RESET,
        flags:     simd_alu_pkg::FLAGS_RESET,
        dest:      simd_alu_pkg::DEST_RESET,
        rdata:     simd_alu_pkg::WORD_RESET,
        default:   1'b0
    };

    state_t            s;
    state_t            next_s;
    logic [1:0]        rst_sync;
    logic              rst_q;
    simd_alu_pkg::op_t cur_op;
    logic              cond_pass;
    logic [3:0]        dest_sel;
    alu_lane_if        alu ();

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_q = rst_sync[1];

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == simd_alu_pkg::ADDR_FIRST)
                 || (a == simd_alu_pkg::ADDR_SECOND)
                 || (a == simd_alu_pkg::ADDR_CONTROL)
                 || (a == simd_alu_pkg::ADDR_RESULT)
                 || (a == simd_alu_pkg::ADDR_FLAGS)
                 || (a == simd_alu_pkg::ADDR_STATUS);
    endfunction

    function automatic logic is_read_only(input logic [7:0] a);
        is_read_only = (a == simd_alu_pkg::ADDR_RESULT)
                    || (a == simd_alu_pkg::ADDR_STATUS);
    endfunction

    // ------------------------------------------------------------------
    // Lane datapath
    // ------------------------------------------------------------------
    assign cur_op    = simd_alu_pkg::op_t'(
        s.ctrl[simd_alu_pkg::CTRL_OP_LSB +: simd_alu_pkg::CTRL_OP_W]);
    assign cond_pass = s.ctrl[simd_alu_pkg::CTRL_COND_BIT];
    assign dest_sel  = s.ctrl[simd_alu_pkg::CTRL_OMIT_BIT]
        ? s.ctrl[simd_alu_pkg::CTRL_FIRST_LSB +: simd_alu_pkg::REG_IDX_W]
        : s.ctrl[simd_alu_pkg::CTRL_DEST_LSB +: simd_alu_pkg::REG_IDX_W];

    assign alu.first  = s.first;
    assign alu.second = s.second;
    assign alu.op     = cur_op;

    packed_lane_alu u_lanes (
        .bus (alu.lanes)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s           = s;
        next_s.result_we = 1'b0;
        if (psel && !penable) begin
            next_s.slverr = !is_mapped(paddr)
                         || (pwrite && is_read_only(paddr));
            case (paddr)
                simd_alu_pkg::ADDR_FIRST:   next_s.rdata = s.first;
                simd_alu_pkg::ADDR_SECOND:  next_s.rdata = s.second;
                simd_alu_pkg::ADDR_CONTROL: next_s.rdata = s.ctrl;
                simd_alu_pkg::ADDR_RESULT:  next_s.rdata = s.result;
                simd_alu_pkg::ADDR_FLAGS: begin
                    next_s.rdata = {28'h000_0000, s.flags};
                end
                simd_alu_pkg::ADDR_STATUS: begin
                    next_s.rdata = {20'h0_0000, s.dest, 3'h0, s.bad,
                                    s.flagged, s.wrote, s.ran, s.pend};
                end
                default: next_s.rdata = 32'h0000_0000;
            endcase
        end
        if (psel && penable && pwrite && !s.slverr) begin
            case (paddr)
                simd_alu_pkg::ADDR_FIRST:  next_s.first = pwdata;
                simd_alu_pkg::ADDR_SECOND: next_s.second = pwdata;
                simd_alu_pkg::ADDR_CONTROL: begin
                    next_s.ctrl = pwdata;
                    next_s.pend = 1'b1;
                end
                simd_alu_pkg::ADDR_FLAGS:  next_s.flags = pwdata[3:0];
                default: next_s.pend = s.pend;
            endcase
        end
        if (s.pend) begin
            next_s.pend    = 1'b0;
            next_s.bad     = !alu.known_op;
            next_s.ran     = cond_pass && alu.known_op;
            next_s.wrote   = cond_pass && alu.writes_result;
            next_s.flagged = cond_pass && alu.updates_flags;
            if (cond_pass && alu.writes_result) begin
                next_s.result    = alu.value;
                next_s.dest      = dest_sel;
                next_s.result_we = 1'b1;
            end
            if (cond_pass && alu.updates_flags) begin
                next_s.flags[simd_alu_pkg::FLAG_N] = alu.value[31];
                next_s.flags[simd_alu_pkg::FLAG_Z] = alu.value == 32'h0;
                if (s.ctrl[simd_alu_pkg::CTRL_CVALID_BIT]) begin
                    next_s.flags[simd_alu_pkg::FLAG_C] =
                        s.ctrl[simd_alu_pkg::CTRL_CARRY_BIT];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_q) begin
        if (!rst_q) begin
            s <= STATE_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // The slave answers with no wait state, so read data is staged in the
    // setup cycle; that keeps prdata a flop while pready stays simple.
    assign pready      = psel && penable;
    assign pslverr     = psel && penable && s.slverr;
    assign prdata      = s.rdata;
    assign result_we   = s.result_we;
    assign result_dest = s.dest;
    assign result_data = s.result;
    assign flags_out   = s.flags;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_q);

    logic [16:0] chk_hlo;
    logic [8:0]  chk_b3;
    logic        packed_op;
    assign chk_hlo = {s.first[15], s.first[15:0]}
                   - {s.second[15], s.second[15:0]};
    assign chk_b3  = {s.first[31], s.first[31:24]}
                   - {s.second[31], s.second[31:24]};
    assign packed_op = alu.known_op && alu.writes_result;

    sequence ctrl_write;
        psel && penable && pwrite && !s.slverr
            && paddr == simd_alu_pkg::ADDR_CONTROL;
    endsequence

    sequence launch(simd_alu_pkg::op_t o);
        s.pend && cur_op == o && cond_pass;
    endsequence

    launch_delay_a: assert property (
        ctrl_write |=> s.pend ##1 !s.pend)
        else $error("Operation did not run one cycle after control write.");

    halving_half_a: assert property (
        launch(simd_alu_pkg::signed_halving_sub_halfwords)
            |=> s.result[15:0] == $past(chk_hlo[16:1]))
        else $error("Halving halfword subtract gave wrong low lane.");

    halving_byte_a: assert property (
        launch(simd_alu_pkg::signed_halving_sub_bytes)
            |=> s.result[31:24] == $past(chk_b3[8:1]))
        else $error("Halving byte subtract gave wrong top lane.");

    packed_flags_a: assert property (
        s.pend && packed_op |=> $stable(s.flags))
        else $error("Packed operation changed the flags.");

    sub_half_a: assert property (
        launch(simd_alu_pkg::signed_sub_halfwords)
            |=> s.result[31:16] == $past(s.first[31:16] - s.second[31:16]))
        else $error("Halfword subtract gave wrong top lane.");

    sub_byte_a: assert property (
        launch(simd_alu_pkg::signed_sub_bytes)
            |=> s.result[7:0] == $past(s.first[7:0] - s.second[7:0]))
        else $error("Byte subtract gave wrong low lane.");

    asx_order_a: assert property (
        launch(simd_alu_pkg::signed_add_sub_exchange)
            |=> s.result[31:16] == $past(s.first[31:16] + s.second[15:0])
             && s.result[15:0] == $past(s.first[15:0] - s.second[31:16]))
        else $error("Add-subtract exchange placed lanes wrongly.");

    sax_order_a: assert property (
        launch(simd_alu_pkg::signed_sub_add_exchange)
            |=> s.result[31:16] == $past(s.first[31:16] - s.second[15:0])
             && s.result[15:0] == $past(s.first[15:0] + s.second[31:16]))
        else $error("Subtract-add exchange placed lanes wrongly.");

    test_nowrite_a: assert property (
        launch(simd_alu_pkg::bit_test)
            |=> $stable(s.result) && !s.result_we
             && s.flags[simd_alu_pkg::FLAG_Z]
                == $past((s.first & s.second) == 32'h0))
        else $error("Bit test wrote a result or set Z wrongly.");

    teq_nowrite_a: assert property (
        launch(simd_alu_pkg::test_equivalence)
            |=> !s.result_we && s.flags[simd_alu_pkg::FLAG_Z]
                == $past(s.first == s.second))
        else $error("Equivalence test wrote a result or set Z wrongly.");

    test_v_hold_a: assert property (
        s.pend && alu.updates_flags
            |=> $stable(s.flags[simd_alu_pkg::FLAG_V]))
        else $error("Test operation changed overflow.");

    teq_sign_a: assert property (
        launch(simd_alu_pkg::test_equivalence)
            |=> s.flags[simd_alu_pkg::FLAG_N]
                == $past(s.first[31] ^ s.second[31]))
        else $error("Equivalence test set N wrongly.");

    add_half_a: assert property (
        launch(simd_alu_pkg::unsigned_add_halfwords)
            |=> s.result[15:0] == $past(s.first[15:0] + s.second[15:0]))
        else $error("Halfword add carried or summed wrongly.");

    add_byte_a: assert property (
        launch(simd_alu_pkg::unsigned_add_bytes)
            |=> s.result[15:8] == $past(s.first[15:8] + s.second[15:8]))
        else $error("Byte add carried or summed wrongly.");

    cond_skip_a: assert property (
        s.pend && !cond_pass
            |=> $stable(s.result) && $stable(s.flags) && !s.result_we)
        else $error("Failed condition still had an effect.");

    dest_omit_a: assert property (
        s.pend && cond_pass && alu.writes_result
            && s.ctrl[simd_alu_pkg::CTRL_OMIT_BIT]
            |=> result_we && result_dest == $past(
                s.ctrl[simd_alu_pkg::CTRL_FIRST_LSB +: 4]))
        else $error("Omitted destination not sent to first register.");

    bus_error_a: assert property (
        psel && !penable && !is_mapped(paddr) ##1 psel && penable
            |-> pslverr && pready)
        else $error("Unmapped access not refused.");
endmodule

// ---- hdl/simd_alu_pkg.sv ----
package simd_alu_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  ADDR_FIRST      = 8'h00;
    localparam logic [7:0]  ADDR_SECOND     = 8'h04;
    localparam logic [7:0]  ADDR_CONTROL    = 8'h08;
    localparam logic [7:0]  ADDR_RESULT     = 8'h0c;
    localparam logic [7:0]  ADDR_FLAGS      = 8'h10;
    localparam logic [7:0]  ADDR_STATUS     = 8'h14;

    // ------------------------------------------------------------------
    // Control word fields
    // ------------------------------------------------------------------
    localparam int          CTRL_OP_LSB     = 0;
    localparam int          CTRL_OP_W       = 4;
    localparam int          CTRL_COND_BIT   = 4;
    localparam int          CTRL_CARRY_BIT  = 5;
    localparam int          CTRL_CVALID_BIT = 6;
    localparam int          CTRL_DEST_LSB   = 8;
    localparam int          CTRL_OMIT_BIT   = 12;
    localparam int          CTRL_FIRST_LSB  = 16;
    localparam int          REG_IDX_W       = 4;

    // ------------------------------------------------------------------
    // Flag positions, status positions and reset values
    // ------------------------------------------------------------------
    localparam int          FLAG_N          = 3;
    localparam int          FLAG_Z          = 2;
    localparam int          FLAG_C          = 1;
    localparam int          FLAG_V          = 0;
    localparam int          ST_BUSY         = 0;
    localparam int          ST_RAN          = 1;
    localparam int          ST_WROTE        = 2;
    localparam int          ST_FLAGGED      = 3;
    localparam int          ST_BAD_OP       = 4;
    localparam int          ST_DEST_LSB     = 8;
    localparam logic [31:0] WORD_RESET      = 32'h0000_0000;
    localparam logic [3:0]  FLAGS_RESET     = 4'h0;
    localparam logic [3:0]  DEST_RESET      = 4'h0;

    typedef enum logic [3:0] {
        unsigned_add_halfwords,
        unsigned_add_bytes,
        signed_sub_halfwords,
        signed_sub_bytes,
        signed_halving_sub_halfwords,
        signed_halving_sub_bytes,
        signed_add_sub_exchange,
        signed_sub_add_exchange,
        bit_test,
        test_equivalence
    } op_t;

endpackage

// ---- hdl/alu_lane_if.sv ----
`timescale 1ns/10ps
interface alu_lane_if;
    logic [31:0]       first;
    logic [31:0]       second;
    simd_alu_pkg::op_t op;
    logic [31:0]       value;
    logic              writes_result;
    logic              updates_flags;
    logic              known_op;

    modport core (
        output first,
        output second,
        output op,
        input  value,
        input  writes_result,
        input  updates_flags,
        input  known_op
    );
    modport lanes (
        input  first,
        input  second,
        input  op,
        output value,
        output writes_result,
        output updates_flags,
        output known_op
    );
endinterface

// ---- hdl/packed_lane_alu.sv ----
`timescale 1ns/10ps
module packed_lane_alu (
    alu_lane_if.lanes bus
);
    logic [31:0] add_b;
    logic [31:0] sub_b;
    logic [31:0] hsub_b;
    logic [31:0] add_h;
    logic [31:0] sub_h;
    logic [31:0] hsub_h;
    logic [15:0] asx_top;
    logic [15:0] asx_bot;
    logic [15:0] sax_top;
    logic [15:0] sax_bot;

    // ------------------------------------------------------------------
    // Byte lanes
    // ------------------------------------------------------------------
    // Lanes are separate adders, so no carry ever crosses a lane edge.
    for (genvar i = 0; i < 4; i++) begin : g_byte
        logic [8:0] diff;
        assign diff = {bus.first[i*8+7], bus.first[i*8+:8]}
                    - {bus.second[i*8+7], bus.second[i*8+:8]};
        assign add_b[i*8+:8]  = bus.first[i*8+:8] + bus.second[i*8+:8];
        assign sub_b[i*8+:8]  = diff[7:0];
        assign hsub_b[i*8+:8] = diff[8:1];
    end

    // ------------------------------------------------------------------
    // Halfword lanes
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_half
        logic [16:0] diff;
        assign diff = {bus.first[i*16+15], bus.first[i*16+:16]}
                    - {bus.second[i*16+15], bus.second[i*16+:16]};
        assign add_h[i*16+:16]  = bus.first[i*16+:16] + bus.second[i*16+:16];
        assign sub_h[i*16+:16]  = diff[15:0];
        assign hsub_h[i*16+:16] = diff[16:1];
    end

    assign asx_top = bus.first[31:16] + bus.second[15:0];
    assign asx_bot = bus.first[15:0] - bus.second[31:16];
    assign sax_top = bus.first[31:16] - bus.second[15:0];
    assign sax_bot = bus.first[15:0] + bus.second[31:16];

    always_comb begin
        bus.value         = 32'h0000_0000;
        bus.writes_result = 1'b1;
        bus.updates_flags = 1'b0;
        bus.known_op      = 1'b1;
        case (bus.op)
            simd_alu_pkg::unsigned_add_halfwords:       bus.value = add_h;
            simd_alu_pkg::unsigned_add_bytes:           bus.value = add_b;
            simd_alu_pkg::signed_sub_halfwords:         bus.value = sub_h;
            simd_alu_pkg::signed_sub_bytes:             bus.value = sub_b;
            simd_alu_pkg::signed_halving_sub_halfwords: bus.value = hsub_h;
            simd_alu_pkg::signed_halving_sub_bytes:     bus.value = hsub_b;
            simd_alu_pkg::signed_add_sub_exchange: begin
                bus.value = {asx_top, asx_bot};
            end
            simd_alu_pkg::signed_sub_add_exchange: begin
                bus.value = {sax_top, sax_bot};
            end
            simd_alu_pkg::bit_test: begin
                bus.value         = bus.first & bus.second;
                bus.writes_result = 1'b0;
                bus.updates_flags = 1'b1;
            end
            simd_alu_pkg::test_equivalence: begin
                bus.value         = bus.first ^ bus.second;
                bus.writes_result = 1'b0;
                bus.updates_flags = 1'b1;
            end
            default: begin
                bus.writes_result = 1'b0;
                bus.known_op      = 1'b0;
            end
        endcase
    end
endmodule

// ---- verification/core_side_model.sv ----
`timescale 1ns/10ps
// ------------
// Core side
// ------------
module core_side_model (
    input  wire logic        ref_clk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata
);
    int idle = 0;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // Released address and write data lines are inverted so a late sampler never sees old data.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] r,
                        output logic e, output logic ok);
        ok = 1'b0;
        repeat (idle + 1) @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge ref_clk);
            ok = (pready === 1'b1);
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule

// ---- verification/packed_simd_alu_tb.sv ----
`timescale 1ns/10ps
module packed_simd_alu_tb;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        result_we;
    logic [3:0]  result_dest;
    logic [31:0] result_data;
    logic [3:0]  flags_out;
    int          errors = 0;
    int          samples_checked = 0;

    always #2 ref_clk = ~ref_clk;

    packed_simd_alu u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .result_we(result_we), .result_dest(result_dest),
        .result_data(result_data), .flags_out(flags_out));
    core_side_model u_core (.ref_clk(ref_clk), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    // ------------
    // Helpers
    // ------------
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            errors++;
        end
    endtask

    task automatic test_done;
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        logic ok;
        u_core.xfer(w, a, d, r, e, ok);
        if (ok !== 1'b1) begin
            errors++;
            test_done;
        end
    endtask

    task automatic run(input logic [31:0] a, input logic [31:0] b,
                       input logic [31:0] ctl, output int pulses);
        logic [31:0] r;
        logic        e;
        pulses = 0;
        bus(1'b1, simd_alu_pkg::ADDR_FIRST, a, r, e);
        bus(1'b1, simd_alu_pkg::ADDR_SECOND, b, r, e);
        bus(1'b1, simd_alu_pkg::ADDR_CONTROL, ctl, r, e);
        repeat (4) begin
            @(posedge ref_clk);
            #1;
            pulses += int'(result_we === 1'b1);
        end
    endtask

    function automatic logic [31:0] want(input logic [3:0] op,
                                         input logic [31:0] a,
                                         input logic [31:0] b);
        logic [31:0] r;
        logic [8:0]  s8;
        logic [16:0] s16;
        for (int i = 0; i < 4; i++) begin
            s8 = {a[8*i+7], a[8*i+:8]} - {b[8*i+7], b[8*i+:8]};
            r[8*i+:8] = (op == 4'h1) ? a[8*i+:8] + b[8*i+:8]
                      : (op == 4'h3) ? s8[7:0] : s8[8:1];
        end
        for (int i = 0; i < 2; i++) begin
            s16 = {a[16*i+15], a[16*i+:16]} - {b[16*i+15], b[16*i+:16]};
            if (op == 4'h0 || op == 4'h2 || op == 4'h4) begin
                r[16*i+:16] = (op == 4'h0) ? a[16*i+:16] + b[16*i+:16]
                            : (op == 4'h2) ? s16[15:0] : s16[16:1];
            end
        end
        if (op == 4'h6) begin
            r = {a[31:16] + b[15:0], a[15:0] - b[31:16]};
        end
        if (op == 4'h7) begin
            r = {a[31:16] - b[15:0], a[15:0] + b[31:16]};
        end
        return r;
    endfunction

    // ------------
    // Scenarios
    // ------------
    task automatic t_bus;
        logic [31:0] r;
        logic        e;
        bus(1'b0, simd_alu_pkg::ADDR_FLAGS, 32'h0, r, e);
        check("flags reset", r, {28'h0, simd_alu_pkg::FLAGS_RESET});
        bus(1'b0, 8'h20, 32'h0, r, e);
        check("unmapped", {e, r[30:0]}, 32'h8000_0000);
        bus(1'b1, simd_alu_pkg::ADDR_RESULT, 32'h5, r, e);
        check("ro write", {31'h0, e}, 32'h1);
        $display("done t_bus");
    endtask

    task automatic t_packed;
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] r;
        logic        e;
        int          n;
        bus(1'b1, simd_alu_pkg::ADDR_FLAGS, 32'ha, r, e);
        for (logic [3:0] op = 4'h0; op < 4'h8; op++) begin
            for (int j = 0; j < 2; j++) begin
                a = j ? 32'h8000_0001 : 32'h7ffe_80ff;
                b = j ? 32'h7fff_ff02 : 32'hffff_7f01;
                run(a, b, 32'h0002_0010 | {20'h0, op, 4'h0, op}, n);
                check("pulse", 32'(n), 32'h1);
                check("data", result_data, want(op, a, b));
                check("dest", {28'h0, result_dest}, {28'h0, op});
                check("flags", {28'h0, flags_out}, 32'ha);
            end
        end
        $display("done t_packed");
    endtask

    task automatic t_tests;
        logic [31:0] keep;
        logic [31:0] r;
        logic        e;
        int          n;
        keep = result_data;
        bus(1'b1, simd_alu_pkg::ADDR_FLAGS, 32'h1, r, e);
        run(32'hf0f0_0000, 32'h0f0f_ffff, 32'h0002_0078, n);
        check("pulse", 32'(n), 32'h0);
        check("flags", {28'h0, flags_out}, 32'h7);
        run(32'h8000_0001, 32'h0000_0001, 32'h0002_0019, n);
        check("pulse", 32'(n), 32'h0);
        check("flags", {28'h0, flags_out}, 32'hb);
        check("data", result_data, keep);
        $display("done t_tests");
    endtask

    task automatic t_cond;
        logic [31:0] keep;
        logic [31:0] r;
        logic        e;
        int          n;
        keep = result_data;
        run(32'h1, 32'h1, 32'h0002_0300, n);
        check("pulse", 32'(n), 32'h0);
        run(32'h1, 32'h1, 32'h0002_0068, n);
        check("flags", {28'h0, flags_out}, 32'hb);
        check("data", result_data, keep);
        // An undefined op code must write nothing and only raise the bad-op status bit.
        run(32'h1, 32'h1, 32'h0002_001a, n);
        check("pulse", 32'(n), 32'h0);
        bus(1'b0, simd_alu_pkg::ADDR_STATUS, 32'h0, r, e);
        check("status", r, 32'h0000_0710);
        $display("done t_cond");
    endtask

    task automatic t_omit;
        logic [31:0] r;
        logic        e;
        int          n;
        u_core.idle = 2;
        run(32'h0001_00ff, 32'h0001_0001, 32'h0005_1911, n);
        check("data", result_data, 32'h0002_0000);
        check("dest", {28'h0, result_dest}, 32'h5);
        bus(1'b0, simd_alu_pkg::ADDR_STATUS, 32'h0, r, e);
        check("status", r, 32'h0000_0506);
        u_core.idle = 0;
        $display("done t_omit");
    endtask

    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        t_bus;
        t_packed;
        t_tests;
        t_cond;
        t_omit;
        test_done;
    end
endmodule
